// file: ext_irq_pkg.sv
// Constants for the external interrupt unit: register map, field positions, vectors, resets.
// Assumes an 8-bit register port clocked by the internal processor clock.
package ext_irq_pkg;

	localparam logic [7:0]  STATUS_CONTROL_OFFSET = 8'h1f;
	localparam logic [7:0]  CORE_STATE_OFFSET     = 8'h20;
	localparam logic [7:0]  SERVICE_OFFSET        = 8'h21;

	localparam int          BIT_PIN_ENABLE        = 7;
	localparam int          BIT_PORT_ENABLE       = 6;
	localparam int          BIT_PIN_FLAG          = 5;
	localparam int          BIT_PORT_FLAG         = 4;
	localparam int          BIT_ACKNOWLEDGE       = 1;

	localparam int          BIT_SVC_MASK_SET      = 0;
	localparam int          BIT_SVC_MASK_CLEAR    = 1;
	localparam int          BIT_SVC_SOFT_TRAP     = 2;
	localparam int          BIT_SVC_STOP_WAIT     = 3;
	localparam int          BIT_SVC_VECTOR_FETCH  = 4;

	localparam logic [15:0] VECTOR_RESET          = 16'h3ffe;
	localparam logic [15:0] VECTOR_SOFT_TRAP      = 16'h3ffc;
	localparam logic [15:0] VECTOR_EXTERNAL       = 16'h3ffa;

	localparam logic        RESET_PIN_ENABLE      = 1'b1;
	localparam logic        RESET_PORT_ENABLE     = 1'b0;
	localparam logic        RESET_MASK            = 1'b1;

	typedef enum logic [1:0] {
		VEC_RESET,
		VEC_SOFT_TRAP,
		VEC_EXTERNAL,
		VEC_NONE
	} vector_sel_t;

endpackage

// file: ext_irq.sv
// External interrupt unit: pin and port edge latches, flags, enables, vector selection.
// Assumes the core pulses service strobes through the register port; pins are asynchronous.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps

module ext_irq
	import ext_irq_pkg::*;
#(
	parameter int          PORT_WIDTH = 8,
	parameter logic        LEVEL_MODE = 1'b0
) (
	input  wire logic                  mclk_in,
	input  wire logic                  rst_in,
	input  wire logic                  irq_pin_n_in,
	input  wire logic [PORT_WIDTH-1:0] port_c_pins_in,
	input  wire logic [PORT_WIDTH-1:0] port_c_dir_in,
	input  wire logic [PORT_WIDTH-1:0] port_c_data_in,
	input  wire logic [7:0]            addr_in,
	input  wire logic [7:0]            wdata_in,
	input  wire logic                  wr_in,
	input  wire logic                  rd_in,
	output logic      [7:0]            rdata_out,
	output logic                       ext_request_out,
	output logic                       interrupt_mask_out,
	output logic      [15:0]           vector_addr_out,
	output logic                       vector_valid_out,
	output logic                       branch_pin_high_out
);

	typedef struct packed {
		logic [2:0]            pin_sync;
		logic [2:0]            port_sync;
		logic [1:0]            level_sync;
		logic                  pin_request_enable;
		logic                  port_request_enable;
		logic                  pin_request_flag;
		logic                  port_request_flag;
		logic                  mask;
		logic                  trap_pending;
		logic [7:0]            rdata;
		logic                  request;
		logic [15:0]           vector;
		logic                  vector_valid;
		logic                  pin_high;
		logic                  pin_clr;
	} state_t;

	state_t     state_r;
	state_t     state_nxt;
	logic       port_eligible_n;
	logic       pin_latch_r;
	logic       port_request_latch_r;
	logic       pin_clr_async;
	vector_sel_t sel;

	// Eligible pins: direction input and data bit clear; others held high
	always_comb begin
		port_eligible_n = 1'b1;
		for (int i = 0; i < PORT_WIDTH; i++) begin
			if (!port_c_dir_in[i] && !port_c_data_in[i]) begin
				port_eligible_n = port_eligible_n & port_c_pins_in[i];
			end
		end
	end

	assign pin_clr_async = state_r.pin_clr | rst_in;

	// Edge latches capture immediately on falling edge of the source
	always_ff @(negedge irq_pin_n_in or posedge pin_clr_async) begin
		if (pin_clr_async) begin
			pin_latch_r <= 1'b0;
		end else begin
			pin_latch_r <= 1'b1;
		end
	end

	always_ff @(negedge port_eligible_n or posedge pin_clr_async) begin
		if (pin_clr_async) begin
			port_request_latch_r <= 1'b0;
		end else begin
			port_request_latch_r <= 1'b1;
		end
	end

	always_comb begin
		logic wr_sc;
		logic wr_svc;
		logic pin_set;
		logic port_set;
		logic pin_edge;
		logic port_edge;
		logic fetch;
		state_nxt = state_r;
		wr_sc = wr_in && (addr_in == STATUS_CONTROL_OFFSET);
		wr_svc = wr_in && (addr_in == SERVICE_OFFSET);
		fetch = wr_svc && wdata_in[BIT_SVC_VECTOR_FETCH];
		state_nxt.pin_sync = {state_r.pin_sync[1:0], pin_latch_r};
		state_nxt.port_sync = {state_r.port_sync[1:0], port_request_latch_r};
		state_nxt.level_sync = {state_r.level_sync[0], ~irq_pin_n_in};
		pin_edge = state_r.pin_sync[1] & ~state_r.pin_sync[2];
		port_edge = state_r.port_sync[1] & ~state_r.port_sync[2];
		pin_set = pin_edge | (LEVEL_MODE & state_r.level_sync[1]);
		port_set = port_edge;
		state_nxt.pin_clr = 1'b0;
		if (wr_sc) begin
			state_nxt.pin_request_enable = wdata_in[BIT_PIN_ENABLE];
			state_nxt.port_request_enable = wdata_in[BIT_PORT_ENABLE];
		end
		if (wr_svc && wdata_in[BIT_SVC_STOP_WAIT]) begin
			state_nxt.pin_request_enable = 1'b1;
		end
		if (wr_svc && wdata_in[BIT_SVC_MASK_SET]) begin
			state_nxt.mask = 1'b1;
		end
		if (wr_svc && wdata_in[BIT_SVC_MASK_CLEAR]) begin
			state_nxt.mask = 1'b0;
		end
		if (wr_svc && wdata_in[BIT_SVC_SOFT_TRAP]) begin
			state_nxt.trap_pending = 1'b1;
		end
		if ((wr_sc && wdata_in[BIT_ACKNOWLEDGE]) || (fetch && state_r.request)) begin
			state_nxt.pin_request_flag = 1'b0;
			state_nxt.pin_clr = 1'b1;
		end
		if (wr_sc && wdata_in[BIT_ACKNOWLEDGE]) begin
			state_nxt.port_request_flag = 1'b0;
		end
		if (pin_set && state_r.pin_request_enable) begin
			state_nxt.pin_request_flag = 1'b1;
		end
		if (port_set) begin
			state_nxt.port_request_flag = 1'b1;
		end
		state_nxt.request = ~state_r.mask &
			((state_r.pin_request_flag & state_r.pin_request_enable) |
			 (state_r.port_request_flag & state_r.port_request_enable));
		if (state_r.request) begin
			sel = VEC_EXTERNAL;
		end else if (state_r.trap_pending) begin
			sel = VEC_SOFT_TRAP;
		end else begin
			sel = VEC_NONE;
		end
		state_nxt.vector_valid = 1'b0;
		if (fetch) begin
			state_nxt.vector_valid = (sel != VEC_NONE);
			case (sel)
				VEC_EXTERNAL: begin
					state_nxt.vector = VECTOR_EXTERNAL;
					state_nxt.mask = 1'b1;
				end
				VEC_SOFT_TRAP: begin
					state_nxt.vector = VECTOR_SOFT_TRAP;
					state_nxt.trap_pending = 1'b0;
					state_nxt.mask = 1'b1;
				end
				default: begin
					state_nxt.vector = state_r.vector;
				end
			endcase
		end
		state_nxt.pin_high = state_r.level_sync[1] ? 1'b0 : 1'b1;
		state_nxt.rdata = 8'h00;
		if (rd_in && (addr_in == STATUS_CONTROL_OFFSET)) begin
			state_nxt.rdata[BIT_PIN_ENABLE] = state_r.pin_request_enable;
			state_nxt.rdata[BIT_PORT_ENABLE] = state_r.port_request_enable;
			state_nxt.rdata[BIT_PIN_FLAG] = state_r.pin_request_flag;
			state_nxt.rdata[BIT_PORT_FLAG] = state_r.port_request_flag;
		end else if (rd_in && (addr_in == CORE_STATE_OFFSET)) begin
			state_nxt.rdata = {5'h00, state_r.trap_pending, state_r.request, state_r.mask};
		end
		if (rst_in) begin
			state_nxt = '0;
			state_nxt.pin_request_enable = RESET_PIN_ENABLE;
			state_nxt.port_request_enable = RESET_PORT_ENABLE;
			state_nxt.mask = RESET_MASK;
			state_nxt.vector = VECTOR_RESET;
			state_nxt.vector_valid = 1'b1;
			state_nxt.pin_high = 1'b1;
		end
	end

	always_ff @(posedge mclk_in) begin
		state_r <= state_nxt;
	end

	assign rdata_out = state_r.rdata;
	assign ext_request_out = state_r.request;
	assign interrupt_mask_out = state_r.mask;
	assign vector_addr_out = state_r.vector;
	assign vector_valid_out = state_r.vector_valid;
	assign branch_pin_high_out = state_r.pin_high;

endmodule // ext_irq

// file: ext_irq_monitor.sv
// Checker on the external interrupt unit ports.
// Assumes edge-only pin mode; bound to every ext_irq instance.
`timescale 1ns/1ps
module ext_irq_monitor
	import ext_irq_pkg::*;
(
	input wire logic        mclk_in,
	input wire logic        rst_in,
	input wire logic        irq_pin_n_in,
	input wire logic [7:0]  addr_in,
	input wire logic [7:0]  wdata_in,
	input wire logic        wr_in,
	input wire logic        rd_in,
	input wire logic [7:0]  rdata_out,
	input wire logic        ext_request_out,
	input wire logic        interrupt_mask_out,
	input wire logic [15:0] vector_addr_out,
	input wire logic        branch_pin_high_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	chk_reset_vector: assert property ($fell(rst_in) |->
		vector_addr_out == VECTOR_RESET && interrupt_mask_out) else $error("reset vector");
	chk_mask_blocks: assert property (interrupt_mask_out [*2] |-> !ext_request_out)
		else $error("request while masked");
	chk_mask_clear: assert property (wr_in && addr_in == SERVICE_OFFSET && wdata_in == 8'h02
		|-> ##[1:2] !interrupt_mask_out) else $error("mask stuck");
	chk_read_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
		else $error("read data outside read");
	chk_status_low: assert property ($past(rd_in && addr_in == STATUS_CONTROL_OFFSET)
		|-> rdata_out[3:0] == 4'h0) else $error("status low bits");
	chk_ack_clears: assert property (wr_in && addr_in == STATUS_CONTROL_OFFSET
		&& wdata_in[BIT_ACKNOWLEDGE] |-> ##2 !ext_request_out) else $error("ack");
	chk_fetch_ext: assert property (wr_in && addr_in == SERVICE_OFFSET && wdata_in == 8'h10
		&& ext_request_out |-> ##[1:2] vector_addr_out == VECTOR_EXTERNAL) else $error("vector");
	chk_pin_level: assert property (!irq_pin_n_in [*5] |-> !branch_pin_high_out)
		else $error("branch level");
endmodule // ext_irq_monitor
bind ext_irq ext_irq_monitor mon (.mclk_in, .rst_in, .irq_pin_n_in, .addr_in, .wdata_in,
	.wr_in, .rd_in, .rdata_out, .ext_request_out, .interrupt_mask_out, .vector_addr_out,
	.branch_pin_high_out);

// file: ext_irq_pins.sv
// Far side model: interrupt pin and port C pins with their port setup.
// Assumes its task is called at a rising clock edge.
`timescale 1ns/1ps
module ext_irq_pins (
	input  wire logic  mclk_in,
	output logic       irq_pin_n_out,
	output logic [7:0] port_pins_out,
	output logic [7:0] port_dir_out,
	output logic [7:0] port_data_out
);
	initial begin
		irq_pin_n_out = 1'b1;
		port_pins_out = 8'hff;
		port_dir_out = 8'h01; // Pin 0 output, others interrupt inputs
		port_data_out = 8'h00;
	end
	// Negative p pulses the interrupt pin, else that port pin
	task automatic pulse(input int p);
		if (p < 0) irq_pin_n_out <= 1'b0;
		else port_pins_out[p] <= 1'b0;
		repeat (6) @(posedge mclk_in);
		irq_pin_n_out <= 1'b1;
		port_pins_out <= 8'hff;
		@(posedge mclk_in);
	endtask
endmodule // ext_irq_pins

// file: ext_irq_tb.sv
// Bench for the external interrupt unit: register port and pin scenarios.
// Assumes edge-only pin mode and the service register layout of the package.
`timescale 1ns/1ps
module ext_irq_tb;
	import ext_irq_pkg::*;
	localparam logic [7:0] ST = STATUS_CONTROL_OFFSET, V = SERVICE_OFFSET, C = CORE_STATE_OFFSET;
	logic        mclk_in = 1'b0;
	logic        rst_in = 1'b0;
	logic        wr_in = 1'b0;
	logic        rd_in = 1'b0;
	logic [7:0]  addr_in = 8'h00;
	logic [7:0]  wdata_in = 8'h00;
	logic        pin_n, ext_request_out, interrupt_mask_out, vector_valid_out, branch_pin_high_out;
	logic [7:0]  pins, dir, data, rdata_out;
	logic [15:0] vector_addr_out;
	int          num_errors = 0;
	int          samples_checked = 0;
	always #2.5 mclk_in = ~mclk_in;
	ext_irq_pins far (.mclk_in, .irq_pin_n_out(pin_n), .port_pins_out(pins),
		.port_dir_out(dir), .port_data_out(data));
	ext_irq uut (.mclk_in, .rst_in, .irq_pin_n_in(pin_n), .port_c_pins_in(pins),
		.port_c_dir_in(dir), .port_c_data_in(data), .addr_in, .wdata_in, .wr_in, .rd_in,
		.rdata_out, .ext_request_out, .interrupt_mask_out, .vector_addr_out,
		.vector_valid_out, .branch_pin_high_out);
	task automatic check(input string n, input logic [15:0] s, e);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic complete_run();
		if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// An empty name makes a write, otherwise a read compared with e
	task automatic bus(input logic [7:0] a, d, e, input string n);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= (n == "");
		rd_in <= (n != "");
		@(posedge mclk_in);
		wr_in <= 1'b0;
		rd_in <= 1'b0;
		#1 if (n != "") check(n, {8'h00, rdata_out}, {8'h00, e});
		@(posedge mclk_in);
	endtask
	task automatic wait_req();
		int i;
		for (i = 0; i < 20 && ext_request_out !== 1'b1; i++) @(posedge mclk_in);
		check("request", ext_request_out, 1'b1);
		if (i == 20) complete_run();
	endtask
	task automatic t_pin();
		check("reset vector", vector_addr_out, VECTOR_RESET);
		bus(ST, 8'h00, 8'h80, "status reset");
		bus(C, 8'h00, 8'h01, "core reset");
		bus(8'h30, 8'h00, 8'h00, "unmapped");
		bus(V, 8'h02, 8'h00, "");
		far.pulse(-1);
		wait_req();
		bus(ST, 8'h00, 8'ha0, "pin flag");
		bus(V, 8'h10, 8'h00, "");
		check("ext vector", vector_addr_out, VECTOR_EXTERNAL);
		bus(ST, 8'h00, 8'h80, "pin cleared");
		check("pin level", branch_pin_high_out, 1'b1);
	endtask
	task automatic t_port();
		bus(V, 8'h02, 8'h00, "");
		far.pulse(0);
		far.pulse(5);
		bus(ST, 8'h00, 8'h90, "port flag");
		check("gated", ext_request_out, 1'b0);
		bus(ST, 8'hf0, 8'h00, "");
		bus(ST, 8'h00, 8'hd0, "flag write");
		wait_req();
		bus(V, 8'h10, 8'h00, "");
		bus(ST, 8'h00, 8'hd0, "port kept");
		bus(V, 8'h02, 8'h00, "");
		wait_req();
		bus(ST, 8'hc0, 8'h00, "");
		bus(ST, 8'h00, 8'hd0, "ack zero");
		bus(ST, 8'hc2, 8'h00, "");
		bus(ST, 8'h00, 8'hc0, "ack");
	endtask
	task automatic t_trap();
		bus(ST, 8'h00, 8'h00, "");
		far.pulse(-1);
		bus(ST, 8'h00, 8'h00, "pin gated");
		bus(ST, 8'h02, 8'h00, "");
		bus(V, 8'h08, 8'h00, "");
		bus(ST, 8'h00, 8'h80, "stop wait");
		bus(V, 8'h01, 8'h00, "");
		far.pulse(-1);
		bus(V, 8'h04, 8'h00, "");
		bus(C, 8'h00, 8'h05, "masked");
		bus(V, 8'h10, 8'h00, "");
		check("trap vector", vector_addr_out, VECTOR_SOFT_TRAP);
		bus(V, 8'h02, 8'h00, "");
		far.pulse(-1);
		wait_req();
		bus(V, 8'h04, 8'h00, "");
		bus(V, 8'h10, 8'h00, "");
		check("first", vector_addr_out, VECTOR_EXTERNAL);
		bus(V, 8'h10, 8'h00, "");
		check("second", vector_addr_out, VECTOR_SOFT_TRAP);
	endtask
	initial begin
		rst_in <= 1'b1;
		repeat (8) @(posedge mclk_in);
		rst_in <= 1'b0;
		@(posedge mclk_in);
		t_pin();
		t_port();
		t_trap();
		complete_run();
	end
endmodule // ext_irq_tb
